// >>> rtl/cgcr_params.svh
`ifndef CGCR_PARAMS_SVH
`define CGCR_PARAMS_SVH
// Register indices of the global block.
`define CGCR_IDX_SOFT_RESET 8'h02
`define CGCR_IDX_DEV_SEL 8'h07
`define CGCR_IDX_PART_ID 8'h20
`define CGCR_IDX_REVISION 8'h21
`define CGCR_IDX_FUNC_PWR 8'h22
`define CGCR_IDX_IDLE_PWR 8'h23
`define CGCR_IDX_GLOBAL_LAST 8'h2f
// Reset values.
`define CGCR_RST_DEV_SEL 8'h00
`define CGCR_RST_FUNC_PWR 8'h00
`define CGCR_RST_IDLE_PWR 8'h00
// Implemented bit masks.
`define CGCR_MASK_FUNC_PWR 8'h7d
`define CGCR_MASK_IDLE_PWR 8'h79
// Soft reset trigger bit position.
`define CGCR_BIT_SOFT_RESET 0
`endif

// >>> rtl/cgcr_pkg.sv
package cgcr_pkg;
    // One host access to the index or data port.
    typedef struct packed {
        logic index_wr;
        logic data_wr;
        logic data_rd;
        logic [7:0] wdata;
    } cgcr_host_req_t;
    // Per-function enables.
    typedef struct packed {
        logic serial3;
        logic serial2;
        logic serial1;
        logic parallel_port;
        logic game_port;
        logic floppy_controller;
    } cgcr_func_bits_t;
endpackage

// >>> rtl/cgcr_regs.sv
`timescale 1ns/100ps
// What this block does
// - Global registers occupy indices 0x00 to 0x2F, apart from per-device space.
// - All eight index bits are decoded so no index aliases another.
// - Unimplemented indices and bits ignore writes and read as zero.
// - The host writes the index port first and the block latches the selection.
// - Data port accesses are routed to the register that the index selects.
// - Index and data accesses are ignored outside configuration mode.
// - Writing one to bit 0 at index 0x02 loads every soft-reset value.
// - The soft reset trigger clears itself right after the write.
// - Index 0x07 selects the logical device and clears on every reset.
// - Activation acts only on the currently selected logical device.
// - Index 0x20 is a fixed read-only identification value.
// - Index 0x21 is a fixed read-only silicon revision value.
// - Index 0x22 holds per-function power enables, bits 1 and 7 reserved.
// - Index 0x23 holds smart idle power enables on bits 0, 3, 4, 5 and 6.
`include "cgcr_params.svh"
module cgcr_regs
    import cgcr_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h3c, // Arbitrary value.
    parameter logic [7:0] REVISION = 8'h01 // Arbitrary value.
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Configuration mode qualifier from the mode-entry logic.
    input wire logic config_mode,
    // Host port accesses.
    input wire cgcr_host_req_t host_req,
    // Read data answered one cycle after a data read.
    output logic [7:0] rdata_q,
    output logic rvalid_q,
    // Device selection and activation steering.
    input wire logic activate_wr,
    input wire logic activate_val,
    output logic [7:0] device_sel_q,
    output logic [255:0] device_active_q,
    // Register outputs to the function blocks.
    output cgcr_func_bits_t func_power_q,
    output cgcr_func_bits_t idle_power_q,
    output logic soft_reset_pulse_q
);

    // Number of logical devices that the 8-bit selector can address.
    localparam int N_DEVICES = 256;

    // Source bit in a stored power byte for each per-function output, floppy first.
    localparam int FUNC_SRC [6] = '{0, 2, 3, 4, 5, 6};

    // Implemented bits of the two power bytes; the others have no flop at all.
    localparam logic [7:0] FUNC_MASK = `CGCR_MASK_FUNC_PWR;
    localparam logic [7:0] IDLE_MASK = `CGCR_MASK_IDLE_PWR;

    // Reset values of the two power bytes.
    localparam logic [7:0] FUNC_RST = `CGCR_RST_FUNC_PWR;
    localparam logic [7:0] IDLE_RST = `CGCR_RST_IDLE_PWR;

    // Latched index.
    logic [7:0] index_q;

    // Stored power bytes, assembled from per-bit flops.
    wire logic [7:0] func_pwr_q;
    wire logic [7:0] idle_pwr_q;

    // Write strobes after the configuration mode gate.
    logic index_wr;
    logic data_wr;

    // Read strobe after the configuration mode gate.
    logic data_rd;

    // Activation strobe after the configuration mode gate.
    logic act_wr;

    // One-hot register selection decoded from the latched index.
    logic [5:0] reg_hit;

    // Soft reset request.
    logic soft_rst_hit;

    // Per-register write enables.
    logic dev_sel_we;
    logic func_pwr_we;
    logic idle_pwr_we;

    // Any reset that loads the soft-reset values.
    logic soft_or_hard;

    // Activation flops collected from their generate loop.
    wire logic [N_DEVICES-1:0] active_bits;

    // Per-function output flops collected from their generate loop.
    wire logic [5:0] func_bits;
    wire logic [5:0] idle_bits;

    // True for an index inside the global register space.
    function automatic logic in_global_space(input logic [7:0] idx);
        return idx <= `CGCR_IDX_GLOBAL_LAST;
    endfunction

    // True when a logical device number matches the current selection.
    function automatic logic is_selected(input logic [7:0] sel, input int dev);
        return sel == 8'(dev);
    endfunction

    // Decodes all eight index bits into a one-hot register selection.
    function automatic logic [5:0] decode_index(input logic [7:0] idx);
        logic [5:0] hit;
        hit = 6'h00;
        if (!in_global_space(idx)) begin
            hit = 6'h00;
        end else if (idx == `CGCR_IDX_SOFT_RESET) begin
            hit = 6'h01;
        end else if (idx == `CGCR_IDX_DEV_SEL) begin
            hit = 6'h02;
        end else if (idx == `CGCR_IDX_PART_ID) begin
            hit = 6'h04;
        end else if (idx == `CGCR_IDX_REVISION) begin
            hit = 6'h08;
        end else if (idx == `CGCR_IDX_FUNC_PWR) begin
            hit = 6'h10;
        end else if (idx == `CGCR_IDX_IDLE_PWR) begin
            hit = 6'h20;
        end else begin
            hit = 6'h00;
        end
        return hit;
    endfunction

    // Keeps only the implemented bits of a stored byte.
    function automatic logic [7:0] keep_bits(input logic [7:0] data, input logic [7:0] mask);
        return data & mask;
    endfunction

    // Builds the read value from the one-hot selection; no selection reads zero.
    function automatic logic [7:0] read_mux(input logic [5:0] hit, input logic [7:0] sel,
                                            input logic [7:0] fp, input logic [7:0] ip);
        logic [7:0] v;
        v = 8'h00;
        if (hit[0]) begin
            v = 8'h00;
        end else if (hit[1]) begin
            v = sel;
        end else if (hit[2]) begin
            v = PART_ID;
        end else if (hit[3]) begin
            v = REVISION;
        end else if (hit[4]) begin
            v = keep_bits(fp, FUNC_MASK);
        end else if (hit[5]) begin
            v = keep_bits(ip, IDLE_MASK);
        end else begin
            v = 8'h00;
        end
        return v;
    endfunction

    // Port strobes qualified by configuration mode.
    assign index_wr = host_req.index_wr & config_mode;
    assign data_wr = host_req.data_wr & config_mode;
    assign data_rd = host_req.data_rd & config_mode;

    // Activation is ignored outside configuration mode as well.
    assign act_wr = activate_wr & config_mode;

    // Register selection from the latched index.
    assign reg_hit = decode_index(index_q);

    // Soft reset request; the trigger bit itself is never stored.
    assign soft_rst_hit = data_wr && reg_hit[0]
                          && host_req.wdata[`CGCR_BIT_SOFT_RESET];

    // Write enables, one per writable register.
    assign dev_sel_we = data_wr && reg_hit[1];
    assign func_pwr_we = data_wr && reg_hit[4];
    assign idle_pwr_we = data_wr && reg_hit[5];

    // A same-cycle write loses against the soft reset.
    assign soft_or_hard = rst || soft_rst_hit;

    // Index latch; only a hard reset clears it.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            index_q <= 8'h00;
        end else if (index_wr) begin
            index_q <= host_req.wdata;
        end
    end

    // Self-clearing soft reset pulse; it lasts exactly one cycle.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            soft_reset_pulse_q <= 1'b0;
        end else begin
            soft_reset_pulse_q <= soft_rst_hit;
        end
    end

    // Logical device selector, cleared by every reset.
    always_ff @(posedge sys_clk) begin
        if (soft_or_hard) begin
            device_sel_q <= `CGCR_RST_DEV_SEL;
        end else if (dev_sel_we) begin
            device_sel_q <= host_req.wdata;
        end
    end

    // Activation bits, one flop per logical device; only the selected one moves.
    for (genvar g = 0; g < N_DEVICES; g++) begin : g_active
        logic bit_q;
        always_ff @(posedge sys_clk) begin
            if (soft_or_hard) begin
                bit_q <= 1'b0;
            end else if (act_wr && is_selected(device_sel_q, g)) begin
                bit_q <= activate_val;
            end
        end
        assign active_bits[g] = bit_q;
    end

    // Activation vector, straight from the per-device flops.
    assign device_active_q = active_bits;

    // Function power enables, cleared by every reset; reserved bits hold no flop.
    for (genvar b = 0; b < 8; b++) begin : g_func_pwr
        if (FUNC_MASK[b]) begin : g_impl
            logic bit_q;
            always_ff @(posedge sys_clk) begin
                if (soft_or_hard) begin
                    bit_q <= FUNC_RST[b];
                end else if (func_pwr_we) begin
                    bit_q <= host_req.wdata[b];
                end
            end
            assign func_pwr_q[b] = bit_q;
        end else begin : g_resv
            assign func_pwr_q[b] = 1'b0;
        end
    end

    // Smart idle enables, kept across soft reset; reserved bits hold no flop.
    for (genvar b = 0; b < 8; b++) begin : g_idle_pwr
        if (IDLE_MASK[b]) begin : g_impl
            logic bit_q;
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    bit_q <= IDLE_RST[b];
                end else if (idle_pwr_we) begin
                    bit_q <= host_req.wdata[b];
                end
            end
            assign idle_pwr_q[b] = bit_q;
        end else begin : g_resv
            assign idle_pwr_q[b] = 1'b0;
        end
    end

    // Per-function output flops, one cycle behind the stored bytes.
    for (genvar g = 0; g < 6; g++) begin : g_func_out
        logic func_q;
        logic idle_q;
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                func_q <= 1'b0;
                idle_q <= 1'b0;
            end else begin
                func_q <= func_pwr_q[FUNC_SRC[g]];
                idle_q <= idle_pwr_q[FUNC_SRC[g]];
            end
        end
        assign func_bits[g] = func_q;
        assign idle_bits[g] = idle_q;
    end

    // Per-function outputs in the carrier layout.
    assign func_power_q = func_bits;
    assign idle_power_q = idle_bits;

    // Read strobe answer, one cycle long.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= data_rd;
        end
    end

    // Read data, held until the next read.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (data_rd) begin
            rdata_q <= read_mux(reg_hit, device_sel_q, func_pwr_q, idle_pwr_q);
        end
    end

endmodule

// >>> tb/cgcr_host_model.sv
`timescale 1ns/100ps
module cgcr_host_model import cgcr_pkg::*; (
    // Clock in, host port strobes out.
    input wire logic sys_clk,
    output cgcr_host_req_t host_req
);
    initial host_req = '0;
    // Holds one port access across one edge; the caller puts index before data.
    task automatic acc(input logic [2:0] k, input logic [7:0] d);
        host_req = {k, d};
        @(posedge sys_clk);
        #1;
    endtask
endmodule

// >>> tb/cgcr_regs_chk.sv
`timescale 1ns/100ps
module cgcr_regs_chk import cgcr_pkg::*; (
    // Clock, reset and host side.
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic config_mode,
    input wire cgcr_host_req_t host_req,
    // Watched outputs.
    input wire logic [7:0] rdata_q,
    input wire logic rvalid_q,
    input wire logic [7:0] device_sel_q,
    input wire logic [255:0] device_active_q,
    input wire cgcr_func_bits_t func_power_q,
    input wire cgcr_func_bits_t idle_power_q,
    input wire logic soft_reset_pulse_q
);
    // All checks share the system clock and its reset.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (config_mode && host_req.data_rd |=> rvalid_q)
        else $error("read not answered");
    a_mode_gate: assert property (!config_mode |=> !rvalid_q && $stable(device_sel_q))
        else $error("access outside config mode");
    a_rdata_hold: assert property (!rvalid_q && !$past(rst) |-> $stable(rdata_q))
        else $error("rdata moved");
    a_srst_clear: assert property (soft_reset_pulse_q |-> device_sel_q == 8'h00)
        else $error("selector kept on soft reset");
    a_srst_func: assert property (soft_reset_pulse_q |=> func_power_q == '0)
        else $error("power enables kept on soft reset");
    a_idle_keep: assert property (soft_reset_pulse_q |=> $stable(idle_power_q))
        else $error("idle enables lost on soft reset");
    a_pulse_once: assert property (soft_reset_pulse_q |=> !soft_reset_pulse_q)
        else $error("soft reset stuck");
    a_idle_game: assert property (!idle_power_q.game_port) else $error("game bit set");
    cover property (soft_reset_pulse_q);
    cover property (rvalid_q && rdata_q != 8'h00);
    cover property (device_active_q != '0);
endmodule
bind cgcr_regs cgcr_regs_chk chk_u (.*);

// >>> tb/cgcr_regs_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
$display("[ERR] %0t %h %h", $time, a, e); end end
module cgcr_regs_tb import cgcr_pkg::*;;
    logic sys_clk = 0, rst = 1, config_mode = 0, activate_wr = 0, activate_val = 0;
    logic rvalid_q, soft_reset_pulse_q;
    logic [7:0] rdata_q, device_sel_q;
    logic [255:0] device_active_q;
    cgcr_host_req_t host_req;
    cgcr_func_bits_t func_power_q, idle_power_q;
    int failures = 0, n_compared = 0;
    // Free-running system clock.
    always #50 sys_clk = ~sys_clk;
    cgcr_host_model hm_u (.sys_clk(sys_clk), .host_req(host_req));
    cgcr_regs #(.PART_ID(8'h4b), .REVISION(8'h02)) dut_u (
        .sys_clk(sys_clk),
        .rst(rst),
        .config_mode(config_mode),
        .host_req(host_req),
        .rdata_q(rdata_q),
        .rvalid_q(rvalid_q),
        .activate_wr(activate_wr),
        .activate_val(activate_val),
        .device_sel_q(device_sel_q),
        .device_active_q(device_active_q),
        .func_power_q(func_power_q),
        .idle_power_q(idle_power_q),
        .soft_reset_pulse_q(soft_reset_pulse_q)
    );
    // Selects an index, writes its data port, then releases the bus.
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        hm_u.acc(3'h4, i);
        hm_u.acc(3'h2, d);
        hm_u.acc(3'h0, ~d);
    endtask
    // Selects an index, reads it and compares the answer.
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        hm_u.acc(3'h4, i);
        hm_u.acc(3'h1, 8'h5a);
        `CHK(rvalid_q, 1'b1)
        `CHK(rdata_q, e)
        hm_u.acc(3'h0, 8'ha5);
    endtask
    // Prints the verdict and ends the run.
    task final_report;
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Main sequence of register accesses.
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 rst = 0;
        wr(8'h07, 8'h05);
        `CHK(device_sel_q, 8'h00)
        config_mode = 1;
        wr(8'h07, 8'h05);
        `CHK(device_sel_q, 8'h05)
        activate_wr = 1;
        activate_val = 1;
        @(posedge sys_clk);
        #1 activate_wr = 0;
        `CHK(device_active_q, 256'h20)
        wr(8'h22, 8'hff);
        wr(8'h23, 8'hff);
        wr(8'ha2, 8'h00);
        wr(8'h20, 8'h00);
        rd(8'h22, 8'h7d);
        rd(8'h23, 8'h79);
        rd(8'ha2, 8'h00);
        rd(8'h2f, 8'h00);
        rd(8'h20, 8'h4b);
        rd(8'h21, 8'h02);
        `CHK(func_power_q, 6'h3f)
        `CHK(idle_power_q, 6'h3d)
        wr(8'h02, 8'h01);
        `CHK(soft_reset_pulse_q, 1'b0)
        `CHK(device_active_q, 256'h0)
        rd(8'h02, 8'h00);
        rd(8'h07, 8'h00);
        rd(8'h22, 8'h00);
        rd(8'h23, 8'h79);
        rst = 1;
        @(posedge sys_clk);
        #1 rst = 0;
        rd(8'h23, 8'h00);
        final_report();
    end
endmodule
